// *** verilog/adcc_pkg.sv ***
// Summary of operation
// - hardware sets conversion-done, csr bit 7, when a result is ready
// - done clears on high result byte read or any csr write with byte lane 0 strobed
// - bit 6 selects converter clock: 0 is pclk/4, 1 is pclk/2
// - writing converter_on bit 5 to one starts converting the selected channel
// - converter_on zero keeps converter disabled and halts conversion
// - channel_select bits 3:0 pick analog input 0 to 15 in binary
// - csr is read/write except done bit, which is read-only, and bit 4, which reads zero
// - result_high_byte is read-only, holding result bits 9:2
// - result_low_bits is read-only: bits 1:0 result, bits 7:2 zero
// - registers sit at indices 70h, 71h, 72h, consecutive
// - reset clears all registers: off, divide by 4, channel 0, not done
// - while on, conversions repeat back to back on the selected channel
// - channel change aborts conversion, clears done, restarts on new channel
package adcc_pkg;
  // ==========================================================
  // register map, index times four is the byte address
  localparam int unsigned ADDR_W       = 12;
  localparam logic [7:0]  CSR_IDX      = 8'h70;
  localparam logic [7:0]  HIGH_IDX     = 8'h71;
  localparam logic [7:0]  LOW_IDX      = 8'h72;
  localparam logic [7:0]  IRQ_STAT_IDX = 8'h73;
  localparam logic [7:0]  IRQ_MASK_IDX = 8'h74;
  // ==========================================================
  // field positions and reset values
  localparam int unsigned DONE_BIT     = 7;
  localparam int unsigned DIV_BIT      = 6;
  localparam int unsigned ON_BIT       = 5;
  localparam int unsigned CH_LSB       = 0;
  localparam int unsigned CH_W         = 4;
  localparam int unsigned RES_W        = 10;
  localparam int unsigned IRQ_W        = 2;
  localparam int unsigned IRQ_DONE     = 0;
  localparam int unsigned IRQ_OVR      = 1;
  localparam logic [7:0]  CSR_RESET    = 8'h00;
  localparam logic [9:0]  RESULT_RESET = 10'h000;
  localparam logic [1:0]  IRQ_RESET    = 2'h0;
  // ==========================================================
  // converter clock ratios
  localparam int unsigned DIV_SLOW     = 4;
  localparam int unsigned DIV_FAST     = 2;
  // ==========================================================
  // types
  typedef struct packed {
    logic            enable;
    logic            start;
    logic            tick;
    logic [CH_W-1:0] channel;
  } adcc_core_ctrl_s;
  typedef struct packed {
    logic             done;
    logic [RES_W-1:0] result;
  } adcc_core_stat_s;
  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_CONV} adcc_state_e;
  // ==========================================================
  // word address match
  function automatic logic adcc_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    return a == {{(ADDR_W-10){1'b0}}, idx, 2'b00};
  endfunction : adcc_hit
endpackage : adcc_pkg

// *** verilog/adcc_clkdiv.sv ***
`timescale 1ns/1ps
`default_nettype none
module adcc_clkdiv #(
  parameter int unsigned SLOW = adcc_pkg::DIV_SLOW,
  parameter int unsigned FAST = adcc_pkg::DIV_FAST
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic fast,
  input  wire logic run,
  output logic      tick
);
  localparam int unsigned CW = $clog2(SLOW);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] last;
  logic          tick_q;
  // ==========================================================
  // divide by four or two
  assign last = fast ? CW'(FAST - 1) : CW'(SLOW - 1);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= '0;
    else if (!run || cnt_q >= last)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + CW'(1);
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tick_q <= 1'b0;
    else
      tick_q <= run && (cnt_q >= last);
  end
  assign tick = tick_q;
endmodule : adcc_clkdiv
`default_nettype wire

// *** verilog/adcc_irq.sv ***
`timescale 1ns/1ps
`default_nettype none
module adcc_irq #(
  parameter int unsigned W = adcc_pkg::IRQ_W
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] events,
  input  wire logic         clr_we,
  input  wire logic         mask_we,
  input  wire logic [W-1:0] wdata,
  output logic      [W-1:0] status,
  output logic      [W-1:0] mask,
  output logic              irq
);
  logic [W-1:0] status_q;
  logic [W-1:0] mask_q;
  logic         irq_q;
  // ==========================================================
  // sticky status, set wins over write-one clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_q <= adcc_pkg::IRQ_RESET;
    else
      status_q <= (status_q & ~(clr_we ? wdata : '0)) | events;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask_q <= adcc_pkg::IRQ_RESET;
    else if (mask_we)
      mask_q <= wdata;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_q <= 1'b0;
    else
      irq_q <= |(status_q & mask_q);
  end
  assign status = status_q;
  assign mask   = mask_q;
  assign irq    = irq_q;
endmodule : adcc_irq
`default_nettype wire

// *** verilog/adcc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module adcc_top (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic [adcc_pkg::ADDR_W-1:0]  paddr,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [31:0]                  pwdata,
  input  wire logic [3:0]                   pstrb,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  output adcc_pkg::adcc_core_ctrl_s         core_ctrl,
  input  wire adcc_pkg::adcc_core_stat_s    core_stat,
  output logic                              irq
);
  // ==========================================================
  // declarations
  logic                                 fast_q;
  logic                                 on_q;
  logic [adcc_pkg::CH_W-1:0]            ch_q;
  logic                                 done_q;
  logic [adcc_pkg::RES_W-1:0]           result_q;
  logic [31:0]                          prdata_q;
  adcc_pkg::adcc_state_e                state_q;
  adcc_pkg::adcc_state_e                state_d;
  logic                                 setup_rd;
  logic                                 access;
  logic                                 wr_access;
  logic                                 rd_access;
  logic                                 lane0;
  logic                                 hit_csr;
  logic                                 hit_high;
  logic                                 hit_low;
  logic                                 hit_stat;
  logic                                 hit_mask;
  logic                                 mapped;
  logic                                 csr_wr;
  logic                                 high_rd;
  logic [adcc_pkg::CH_W-1:0]            ch_new;
  logic                                 ch_change;
  logic                                 conv_done;
  logic                                 rearm_q;
  logic                                 tick;
  logic [adcc_pkg::IRQ_W-1:0]           irq_events;
  logic [adcc_pkg::IRQ_W-1:0]           irq_status;
  logic [adcc_pkg::IRQ_W-1:0]           irq_mask;
  logic [7:0]                           csr_view;
  logic [7:0]                           high_view;
  logic [7:0]                           low_view;
  logic [31:0]                          rd_mux;

  // ==========================================================
  // address decode
  assign hit_csr  = adcc_pkg::adcc_hit(paddr, adcc_pkg::CSR_IDX);
  assign hit_high = adcc_pkg::adcc_hit(paddr, adcc_pkg::HIGH_IDX);
  assign hit_low  = adcc_pkg::adcc_hit(paddr, adcc_pkg::LOW_IDX);
  assign hit_stat = adcc_pkg::adcc_hit(paddr, adcc_pkg::IRQ_STAT_IDX);
  assign hit_mask = adcc_pkg::adcc_hit(paddr, adcc_pkg::IRQ_MASK_IDX);
  assign mapped   = hit_csr | hit_high | hit_low | hit_stat | hit_mask;

  // ==========================================================
  // bus phases
  assign setup_rd  = psel && !penable && !pwrite;
  assign access    = psel && penable;
  assign lane0     = pstrb[0];
  assign wr_access = access && pwrite && mapped && lane0;
  assign rd_access = access && !pwrite && mapped;
  assign csr_wr    = wr_access && hit_csr;
  assign high_rd   = rd_access && hit_high;

  // ==========================================================
  // single-cycle access phase
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;

  // ==========================================================
  // channel change detect
  assign ch_new    = pwdata[adcc_pkg::CH_LSB +: adcc_pkg::CH_W];
  assign ch_change = csr_wr && (ch_new != ch_q);

  // ==========================================================
  // control fields
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fast_q <= adcc_pkg::CSR_RESET[adcc_pkg::DIV_BIT];
    else if (csr_wr)
      fast_q <= pwdata[adcc_pkg::DIV_BIT];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      on_q <= adcc_pkg::CSR_RESET[adcc_pkg::ON_BIT];
    else if (csr_wr)
      on_q <= pwdata[adcc_pkg::ON_BIT];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ch_q <= adcc_pkg::CSR_RESET[adcc_pkg::CH_LSB +: adcc_pkg::CH_W];
    else if (csr_wr)
      ch_q <= ch_new;
  end

  // ==========================================================
  // converter clock enable
  adcc_clkdiv #(
    .SLOW (adcc_pkg::DIV_SLOW),
    .FAST (adcc_pkg::DIV_FAST)
  ) u_clkdiv (
    .pclk    (pclk),
    .presetn (presetn),
    .fast    (fast_q),
    .run     (on_q),
    .tick    (tick)
  );

  // ==========================================================
  // conversion sequencer
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      adcc_pkg::ST_IDLE:
      begin
        if (on_q)
          state_d = adcc_pkg::ST_START;
      end
      adcc_pkg::ST_START:
      begin
        if (!on_q)
          state_d = adcc_pkg::ST_IDLE;
        else
          state_d = adcc_pkg::ST_CONV;
      end
      adcc_pkg::ST_CONV:
      begin
        if (!on_q)
          state_d = adcc_pkg::ST_IDLE;
        else if (ch_change || rearm_q)
          state_d = adcc_pkg::ST_START;
        else if (core_stat.done)
          state_d = adcc_pkg::ST_START;
      end
      default:
      begin
        state_d = adcc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= adcc_pkg::ST_IDLE;
    else
      state_q <= state_d;
  end

  // ==========================================================
  // channel change in the start cycle re-arms a fresh start
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rearm_q <= 1'b0;
    else if (!on_q)
      rearm_q <= 1'b0;
    else if (ch_change && (state_q == adcc_pkg::ST_START))
      rearm_q <= 1'b1;
    else if (state_q == adcc_pkg::ST_CONV)
      rearm_q <= 1'b0;
  end

  // completion counts only for the running, unaborted conversion
  assign conv_done = (state_q == adcc_pkg::ST_CONV) && on_q && !ch_change && !rearm_q && core_stat.done;

  // ==========================================================
  // result word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      result_q <= adcc_pkg::RESULT_RESET;
    else if (conv_done)
      result_q <= core_stat.result;
  end

  // ==========================================================
  // conversion-done flag, set wins over clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      done_q <= adcc_pkg::CSR_RESET[adcc_pkg::DONE_BIT];
    else if (conv_done)
      done_q <= 1'b1;
    else if (csr_wr || high_rd)
      done_q <= 1'b0;
  end

  // ==========================================================
  // core drive
  always_comb
  begin
    core_ctrl         = '0;
    core_ctrl.enable  = on_q;
    core_ctrl.start   = (state_q == adcc_pkg::ST_START) && on_q;
    core_ctrl.tick    = tick;
    core_ctrl.channel = ch_q;
  end

  // ==========================================================
  // interrupts: done and overrun
  always_comb
  begin
    irq_events                    = '0;
    irq_events[adcc_pkg::IRQ_DONE] = conv_done;
    irq_events[adcc_pkg::IRQ_OVR]  = conv_done && done_q;
  end

  adcc_irq #(
    .W (adcc_pkg::IRQ_W)
  ) u_irq (
    .pclk    (pclk),
    .presetn (presetn),
    .events  (irq_events),
    .clr_we  (wr_access && hit_stat),
    .mask_we (wr_access && hit_mask),
    .wdata   (pwdata[adcc_pkg::IRQ_W-1:0]),
    .status  (irq_status),
    .mask    (irq_mask),
    .irq     (irq)
  );

  // ==========================================================
  // register views
  always_comb
  begin
    csr_view                                          = '0;
    csr_view[adcc_pkg::DONE_BIT]                      = done_q;
    csr_view[adcc_pkg::DIV_BIT]                       = fast_q;
    csr_view[adcc_pkg::ON_BIT]                        = on_q;
    csr_view[adcc_pkg::CH_LSB +: adcc_pkg::CH_W]      = ch_q;
  end

  assign high_view = result_q[adcc_pkg::RES_W-1 -: 8];
  assign low_view  = {6'h00, result_q[1:0]};

  // ==========================================================
  // read mux
  always_comb
  begin
    rd_mux = '0;
    if (hit_csr)
      rd_mux[7:0] = csr_view;
    else if (hit_high)
      rd_mux[7:0] = high_view;
    else if (hit_low)
      rd_mux[7:0] = low_view;
    else if (hit_stat)
      rd_mux[adcc_pkg::IRQ_W-1:0] = irq_status;
    else if (hit_mask)
      rd_mux[adcc_pkg::IRQ_W-1:0] = irq_mask;
  end

  // ==========================================================
  // read data captured in setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= '0;
    else if (setup_rd)
      prdata_q <= rd_mux;
  end

  assign prdata = prdata_q;

endmodule : adcc_top
`default_nettype wire

// *** tb/adcc_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
// ====================
// apb and core control checks
module adcc_checker (
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic [adcc_pkg::ADDR_W-1:0] paddr,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [31:0]                 pwdata,
  input wire logic [3:0]                  pstrb,
  input wire logic [31:0]                 prdata,
  input wire logic                        pslverr,
  input wire adcc_pkg::adcc_core_ctrl_s   core_ctrl
);
  logic acc;
  logic wr_csr;
  assign acc = psel && penable;
  assign wr_csr = acc && pwrite && pstrb[0] && paddr == 12'h1c0;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  map_error_a: assert property (acc |-> pslverr ==
    !(paddr inside {12'h1c0, 12'h1c4, 12'h1c8, 12'h1cc, 12'h1d0})) else $error("slave error wrong");
  on_follows_a: assert property (wr_csr |=> core_ctrl.enable == $past(pwdata[5]))
    else $error("enable not as written");
  chan_follows_a: assert property (wr_csr |=> core_ctrl.channel == $past(pwdata[3:0]))
    else $error("channel not as written");
  start_on_write_a: assert property (wr_csr && pwdata[5] && !core_ctrl.enable |-> ##2 core_ctrl.start)
    else $error("no start");
  chan_restart_a: assert property (wr_csr && pwdata[5] && core_ctrl.enable && !core_ctrl.start &&
    pwdata[3:0] != core_ctrl.channel |=> core_ctrl.start) else $error("no restart");
  start_pulse_a: assert property (core_ctrl.start |=> !core_ctrl.start)
    else $error("start too long");
  start_needs_on_a: assert property (core_ctrl.start |-> core_ctrl.enable)
    else $error("start while off");
  tick_pulse_a: assert property (core_ctrl.tick |=> !core_ctrl.tick)
    else $error("tick too long");
  off_no_tick_a: assert property (!core_ctrl.enable && $past(!core_ctrl.enable) |-> !core_ctrl.tick)
    else $error("tick while off");
  low_zero_a: assert property (acc && !pwrite && paddr == 12'h1c8 |-> prdata[31:2] == 30'h0)
    else $error("low byte upper bits set");
  csr_bit4_a: assert property (acc && !pwrite && paddr == 12'h1c0 |-> prdata[4] == 1'b0)
    else $error("reserved bit set");
endmodule : adcc_checker
bind adcc_top adcc_checker chk_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pslverr(pslverr), .core_ctrl(core_ctrl));
`default_nettype wire

// *** tb/adcc_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ====================
// converter core stand-in
module adcc_core_model (
  input wire logic                      pclk,
  input wire logic                      presetn,
  input wire adcc_pkg::adcc_core_ctrl_s ctrl,
  input wire logic [3:0]                nticks,
  input wire logic [9:0]                res,
  output var adcc_pkg::adcc_core_stat_s stat
);
  logic       busy_q;
  logic [3:0] cnt_q;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      busy_q <= 1'b0;
      cnt_q  <= 4'h0;
      stat   <= '0;
    end
    else
    begin
      stat.done   <= 1'b0;
      stat.result <= ~stat.result;
      if (!ctrl.enable)
        busy_q <= 1'b0;
      else if (ctrl.start)
      begin
        busy_q <= 1'b1;
        cnt_q  <= 4'h0;
      end
      else if (busy_q && ctrl.tick && cnt_q == nticks)
      begin
        busy_q <= 1'b0;
        stat   <= {1'b1, res};
      end
      else if (busy_q && ctrl.tick)
        cnt_q <= cnt_q + 4'h1;
    end
endmodule : adcc_core_model
`default_nettype wire

// *** tb/test_adc_control_registers.sv ***
`timescale 1ns/1ps
`default_nettype none
// ====================
// bench
module test_adc_control_registers;
  logic                      pclk = 1'b0;
  logic                      presetn = 1'b0;
  logic [11:0]               paddr = 12'h0;
  logic                      psel = 1'b0;
  logic                      penable = 1'b0;
  logic                      pwrite = 1'b0;
  logic [31:0]               pwdata = 32'h0;
  logic [3:0]                pstrb = 4'hf;
  logic [31:0]               prdata;
  logic                      pready;
  logic                      pslverr;
  adcc_pkg::adcc_core_ctrl_s core_ctrl;
  adcc_pkg::adcc_core_stat_s core_stat;
  logic                      irq;
  logic [9:0]                res = 10'h0;
  logic [3:0]                nt = 4'hf;
  logic [31:0]               rnd = 32'ha35c;
  logic [31:0]               q;
  logic                      err;
  int                        bad_count = 0;
  int                        samples_checked = 0;
  always #50 pclk = ~pclk;
  adcc_top dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_ctrl(core_ctrl), .core_stat(core_stat), .irq(irq));
  adcc_core_model core_u (.pclk(pclk), .presetn(presetn), .ctrl(core_ctrl), .nticks(nt),
    .res(res), .stat(core_stat));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [31:0] exp_csr(input logic [7:0] d);
    return {24'h0, d & 8'h6f};
  endfunction : exp_csr
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask : chk
  task automatic tmo;
    chk(32'h0, 32'h1);
    conclude();
  endtask : tmo
  task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      tmo();
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_done;
    int n;
    n = 0;
    do
    begin
      apb(12'h1c0, 1'b0, 8'h0);
      n++;
    end
    while (q[7] !== 1'b1 && n < 200);
    if (n >= 200)
      tmo();
  endtask : wait_done
  task automatic tick_gap(output int g);
    int n;
    n = 0;
    g = 0;
    do @(negedge pclk); while (core_ctrl.tick !== 1'b1 && ++n < 50);
    do @(negedge pclk); while (core_ctrl.tick !== 1'b1 && ++g < 50);
    g++;
  endtask : tick_gap
  initial
  begin
    int g;
    logic [7:0] d;
    logic [3:0] ch;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      apb(12'h1c0 + 12'(4 * i), 1'b0, 8'h0);
      chk(q, 32'h0);
    end
    for (int i = 0; i < 16; i++)
    begin
      rnd = lfsr(rnd);
      d = {rnd[7:6], 2'b00, 4'(i)};
      apb(12'h1c0, 1'b1, d);
      apb(12'h1c0, 1'b0, 8'h0);
      chk(q, exp_csr(d));
    end
    pstrb <= 4'he;
    apb(12'h1c0, 1'b1, 8'h4a);
    pstrb <= 4'hf;
    apb(12'h1c4, 1'b1, 8'hff);
    apb(12'h1c4, 1'b0, 8'h0);
    chk(q, 32'h0);
    apb(12'h1c0, 1'b0, 8'h0);
    chk(q, exp_csr(d));
    apb(12'h1d4, 1'b0, 8'h0);
    chk({31'h0, err}, 32'h1);
    for (int s = 0; s < 2; s++)
    begin
      rnd = lfsr(rnd);
      res <= rnd[9:0];
      nt <= s ? 4'hf : 4'h7;
      ch = rnd[13:10];
      apb(12'h1d0, 1'b1, 8'(s));
      apb(12'h1c0, 1'b1, {1'b0, 1'(s), 2'b10, ch});
      tick_gap(g);
      chk(g, s ? 2 : 4);
      wait_done;
      chk({31'h0, irq}, s);
      apb(12'h1cc, 1'b0, 8'h0);
      chk(q, 32'h1);
      apb(12'h1c8, 1'b0, 8'h0);
      chk(q, {30'h0, res[1:0]});
      apb(12'h1c4, 1'b0, 8'h0);
      chk(q, {24'h0, res[9:2]});
      apb(12'h1c0, 1'b0, 8'h0);
      chk({31'h0, q[7]}, 32'h0);
      apb(12'h1cc, 1'b1, 8'h03);
      apb(12'h1cc, 1'b0, 8'h0);
      chk(q, 32'h0);
      chk({31'h0, irq}, 32'h0);
    end
    rnd = lfsr(rnd);
    res <= rnd[9:0];
    wait_done;
    apb(12'h1c4, 1'b0, 8'h0);
    chk(q, {24'h0, res[9:2]});
    wait_done;
    d = {4'h6, ~ch};
    apb(12'h1c0, 1'b1, d);
    apb(12'h1c0, 1'b0, 8'h0);
    chk(q, exp_csr(d));
    wait_done;
    apb(12'h1c0, 1'b1, 8'h00);
    apb(12'h1cc, 1'b1, 8'h03);
    repeat (100) @(posedge pclk);
    apb(12'h1cc, 1'b0, 8'h0);
    chk(q, 32'h0);
    apb(12'h1c0, 1'b0, 8'h0);
    chk(q, 32'h0);
    conclude();
  end
endmodule : test_adc_control_registers
`default_nettype wire
